// File: hdl/jss_link_init.sv
// Link start-up sequencer driven by the selected sync request
`timescale 1ns/10ps
module jss_link_init
    import jss_pkg::*;
#(
    parameter logic [MF_CNT_W-1:0] MF_LEN = MF_LEN_DEFAULT
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sync_source_select,
    input wire logic timestamp_receiver_enable,
    input wire logic link_encoding,
    input wire logic link_enable,
    input wire logic single_ended_sync_request_n,
    input wire logic differential_timestamp_pair_n,
    input wire logic sysref,
    output logic cgs_active,
    output logic align_active,
    output logic data_active,
    output logic align_multiframe_start,
    output logic oscillator_sync_pulse,
    output logic sync_seen
);
    jss_state_t state;
    jss_state_t next_state;
    logic sync_request;
    logic sync_request_d;
    logic sysref_d;
    logic sysref_edge;
    logic [MF_CNT_W-1:0] mf_cnt;
    logic [2:0] align_cnt;

    // Last cycle of a multiframe, shared by the counter and the sequencer
    function automatic logic mf_last(input logic [MF_CNT_W-1:0] cnt);
        return cnt == MF_LEN - MF_CNT_ONE;
    endfunction

    jss_sync_select u_sel (
        .mclk(mclk),
        .nrst(nrst),
        .sync_source_select(sync_source_select),
        .timestamp_receiver_enable(timestamp_receiver_enable),
        .single_ended_sync_request_n(single_ended_sync_request_n),
        .differential_timestamp_pair_n(differential_timestamp_pair_n),
        .sync_request(sync_request)
    );

    assign sysref_edge = sysref & ~sysref_d;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sync_request_d <= 1'b0;
        end else begin
            sync_request_d <= sync_request;
        end
    end

    // Reset low so a reference held high at release counts as an edge
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sysref_d <= 1'b0;
        end else begin
            sysref_d <= sysref;
        end
    end

    // Multiframe counter re-phased on each reference edge for fixed latency
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            mf_cnt <= MF_CNT_ZERO;
        end else if (sysref_edge || mf_last(mf_cnt)) begin
            mf_cnt <= MF_CNT_ZERO;
        end else begin
            mf_cnt <= mf_cnt + MF_CNT_ONE;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            JSS_IDLE: begin
                if (link_enable && link_encoding == ENC_8B10B && sync_request) begin
                    next_state = JSS_CGS;
                end
            end
            JSS_CGS: begin
                if (!sync_request) begin
                    next_state = JSS_ALIGN;
                end
            end
            JSS_ALIGN: begin
                if (sync_request) begin
                    next_state = JSS_CGS;
                end else if (mf_last(mf_cnt) && align_cnt == 3'(ALIGN_MULTIFRAMES - 1)) begin
                    next_state = JSS_DATA;
                end
            end
            JSS_DATA: begin
                // Re-request restarts code group sync
                if (sync_request) begin
                    next_state = JSS_CGS;
                end
            end
            default: next_state = JSS_IDLE;
        endcase
        if (!link_enable || link_encoding == ENC_64B66B) begin
            next_state = JSS_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state <= JSS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Alignment sequence length counted in multiframes
    always_ff @(posedge mclk) begin
        if (!nrst || state != JSS_ALIGN) begin
            align_cnt <= ALIGN_CNT_ZERO;
        end else if (mf_last(mf_cnt)) begin
            align_cnt <= align_cnt + ALIGN_CNT_ONE;
        end
    end

    // Phase and multiframe-start outputs decoded from the next state so they line up with the state register
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cgs_active <= 1'b0;
        end else begin
            cgs_active <= (next_state == JSS_CGS);
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            align_active <= 1'b0;
        end else begin
            align_active <= (next_state == JSS_ALIGN);
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            data_active <= 1'b0;
        end else begin
            data_active <= (next_state == JSS_DATA);
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            align_multiframe_start <= 1'b0;
        end else begin
            align_multiframe_start <= (next_state == JSS_ALIGN) && (state != JSS_ALIGN);
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            oscillator_sync_pulse <= 1'b0;
        end else begin
            oscillator_sync_pulse <= link_encoding == ENC_64B66B
                                     && sync_request && !sync_request_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sync_seen <= 1'b0;
        end else begin
            sync_seen <= sync_request;
        end
    end
endmodule // jss_link_init

// File: hdl/jss_pkg.sv
// Constants for the sync source select and link start-up sequencer
// Behaviour
// - Select 0 in 8b/10b: single-ended sync input is active-low link initialization request
// - 64b/66b modes ignore sync for start-up; it may pulse oscillator synchronization
// - Low sync in 8b/10b starts code group synchronization on the lanes
// - Receiver raises sync after code group sync; rising level starts lane alignment
// - Select 1 takes the sync request from the differential timestamp pair
// - Reference input edge times synchronization and deterministic latency
// - Differential timestamp pair sync is active-low like the single-ended input
// - Differential timestamp pair usable only when timestamp receiver enable is 1
package jss_pkg;
    localparam logic SEL_SINGLE = 1'b0;
    localparam logic SEL_DIFF = 1'b1;
    localparam logic ENC_8B10B = 1'b0;
    localparam logic ENC_64B66B = 1'b1;
    localparam int ALIGN_MULTIFRAMES = 4;
    localparam int MF_CNT_W = 8;
    localparam logic [MF_CNT_W-1:0] MF_CNT_ZERO = 8'h00;
    localparam logic [MF_CNT_W-1:0] MF_CNT_ONE = 8'h01;
    localparam logic [MF_CNT_W-1:0] MF_LEN_DEFAULT = 8'h20;
    localparam logic [2:0] ALIGN_CNT_ZERO = 3'h0;
    localparam logic [2:0] ALIGN_CNT_ONE = 3'h1;
    typedef enum logic [1:0] {
        JSS_IDLE = 2'b00,
        JSS_CGS = 2'b01,
        JSS_ALIGN = 2'b11,
        JSS_DATA = 2'b10
    } jss_state_t;
endpackage

// File: hdl/jss_sync_select.sv
// Sync request source selection and polarity
`timescale 1ns/10ps
module jss_sync_select
    import jss_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sync_source_select,
    input wire logic timestamp_receiver_enable,
    input wire logic single_ended_sync_request_n,
    input wire logic differential_timestamp_pair_n,
    output logic sync_request
);
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            sync_request <= 1'b0;
        end else if (sync_source_select == SEL_DIFF) begin
            sync_request <= timestamp_receiver_enable & ~differential_timestamp_pair_n;
        end else begin
            sync_request <= ~single_ended_sync_request_n;
        end
    end
endmodule // jss_sync_select

// File: verification/jss_link_init_assertions.sv
// Checker for the link start-up sequencer
`timescale 1ns/10ps
module jss_link_init_assertions (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic link_encoding,
    input wire logic link_enable,
    input wire logic cgs_active,
    input wire logic align_active,
    input wire logic data_active,
    input wire logic align_multiframe_start,
    input wire logic oscillator_sync_pulse,
    input wire logic sync_seen
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    chk_cgs_go: assert property (sync_seen && $past(link_enable) && !$past(link_encoding) |-> cgs_active)
        else $error("cgs");
    chk_idle_wide: assert property (link_encoding |=> !cgs_active && !align_active)
        else $error("idle");
    chk_align_go: assert property ($fell(sync_seen) && $past(cgs_active) && $past(link_enable)
        && !$past(link_encoding) |-> align_active)
        else $error("align");
    chk_mf_start: assert property (align_multiframe_start |-> $rose(align_active))
        else $error("mf");
    chk_align_end: assert property ($rose(align_active) |-> ##[1:200] !align_active)
        else $error("end");
    chk_data_src: assert property ($rose(data_active) |-> $past(align_active))
        else $error("data");
    chk_osc_wide: assert property (oscillator_sync_pulse |-> $past(link_encoding))
        else $error("osc");
    chk_one_phase: assert property ($onehot0({cgs_active, align_active, data_active}))
        else $error("phase");
endmodule // jss_link_init_assertions
bind jss_link_init jss_link_init_assertions chk (.*);

// File: verification/jss_rx_model.sv
// Receiver model that drives the sync request
`timescale 1ns/10ps
module jss_rx_model (
    input wire logic mclk,
    input wire logic restart,
    input wire logic cgs_active,
    output logic sync_n
);
    logic [2:0] dwell;
    // Raise sync after code group sync
    always @(posedge mclk) begin
        dwell <= restart ? 3'h0 : dwell + {2'h0, cgs_active};
        sync_n <= !restart && (sync_n || dwell == 3'h7);
    end
endmodule // jss_rx_model

// File: verification/jss_link_init_tb.sv
// Testbench for the link start-up sequencer
`timescale 1ns/10ps
module jss_link_init_tb;
    logic mclk = 1'b0, nrst = 1'b0, rx_rst = 1'b1;
    logic sel, ts, enc, se_n, df_n, cgs, aln, dat, mfs, osc, seen, rx_n;
    logic [6:0] rows [6] = '{7'h07, 7'h28, 7'h64, 7'h6b, 7'h48, 7'h16};
    logic [1:0] mf_hits;
    int errors = 0, tests_run = 0;
    jss_link_init #(.MF_LEN(8'h04)) DUT (.mclk(mclk), .nrst(nrst), .sync_source_select(sel),
        .timestamp_receiver_enable(ts), .link_encoding(enc), .link_enable(1'b1),
        .single_ended_sync_request_n(se_n), .differential_timestamp_pair_n(df_n),
        .sysref(1'b0), .cgs_active(cgs), .align_active(aln), .data_active(dat),
        .align_multiframe_start(mfs), .oscillator_sync_pulse(osc), .sync_seen(seen));
    jss_rx_model RX (.mclk(mclk), .restart(rx_rst), .cgs_active(cgs), .sync_n(rx_n));
    initial forever #2.5 mclk = ~mclk;
    // Unused source pin: grounded if pair, inverted receiver sync if single-ended
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge mclk);
            #1;
            if (!rx_rst) {se_n, df_n} = sel ? {1'b0, rx_n} : {rx_n, ~rx_n};
        end
    endtask
    task automatic check(input logic [1:0] got, input logic [1:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t %h %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        if (errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        {sel, ts, enc, se_n, df_n} = 5'h03;
        tick(4);
        check({cgs | aln | dat, mfs | osc | seen}, 2'h0);
        nrst = 1'b1;
        foreach (rows[i]) begin
            {sel, ts, enc, se_n, df_n} = rows[i][6:2];
            tick(3);
            check({seen, cgs}, rows[i][1:0]);
        end
        {ts, enc} = 2'h2;
        for (int s = 0; s < 2; s++) begin
            {sel, rx_rst} = {s[0], 1'b0};
            tick(4);
            check({cgs, dat}, 2'h2);
            mf_hits = 2'h0;
            for (int k = 0; k < 200 && dat !== 1'b1; k++) begin
                tick(1);
                mf_hits = mf_hits + {1'b0, mfs};
            end
            check({cgs, dat}, 2'h1);
            check(mf_hits, 2'h1);
            rx_rst = 1'b1;
            tick(1);
        end
        {sel, enc, se_n, nrst} = 4'h6;
        tick(2);
        check({cgs | aln | dat, mfs | osc | seen}, 2'h0);
        nrst = 1'b1;
        tick(2);
        se_n = 1'b0;
        tick(2);
        check({osc, cgs}, 2'h2);
        tick(1);
        check({osc, seen}, 2'h1);
        print_verdict();
    end
endmodule // jss_link_init_tb
